// File: rtctk_counters.sv
/*
 Timekeeping counters: 1/128 s ticks, seconds, minutes, hours, interval
 alarm and compensation trims, reached through special-function registers.
 Assumes the crystal clock arrives asynchronously, that sysRst is a
 watchdog or external reset from logic on clk_sys, and rst is power-on.

// Overview of operation
// - Fraction ticks 128 per second, carry seconds.
// - Seconds wrap after 59, carry minutes.
// - Minutes wrap after 59, carry hours.
// - 24-hour mode wraps at 23, flags day.
// - 256-hour mode wraps at 255, flags day.
// - Counters survive watchdog/external reset, clear on power-on.
// - Interval reaching target sets alarm flag.
// - Interval counter and target are eight bits.
// - Nominal trim register, software writable, eight bits.
// - Nominal trim cleared by every reset.
// - Mode bit picks 24 or 256 hours.
// - One-shot stops after first alarm.
// - Counter writes need key, key then cleared.
*/
`timescale 1ns/1ps
`default_nettype none
module rtctk_counters (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic sysRst,
   input wire logic xtalClk,
   input wire rtctk_pkg::rtctk_sfr_s sfrBus,
   output logic [7:0] sfrRdData,
   output logic clkIrq
);
   import rtctk_pkg::*;

   // Wrapping increment, used by every timekeeping counter.
   function automatic logic [7:0] wrapInc(input logic [7:0] v, input logic [7:0] last);
      wrapInc = (v >= last) ? RST_BYTE : v + 8'h_01;
   endfunction

   // Crystal synchroniser; only the second stage feeds logic.
   logic xSync1_r, xSync2_r, xPrev_r;
   logic [9:0] edgeCnt_r; // Crystal edges seen in the current tick.
   logic [7:0] frac_r, sec_r, min_r, hour_r; // Timekeeping counters.
   logic [7:0] intTarget_r, intCount_r; // Interval target and progress.
   logic oneShotDone_r; // A one-shot interval has fired.
   logic [7:0] nominal_r, thermal_r, key_r; // Trims and unlock key.
   rtctk_cfg_s cfg_r; // Configuration and flags.
   logic [7:0] rdData_r; // Registered read data.
   logic irq_r; // Registered interrupt request.

   // Decode of bus writes; counter writes need the unlock key.
   wire keyOk = (key_r == KEY_UNLOCK);
   wire wrFrac = sfrBus.we && sfrBus.addr == OFF_FRAC && keyOk;
   wire wrSec = sfrBus.we && sfrBus.addr == OFF_SEC && keyOk;
   wire wrMin = sfrBus.we && sfrBus.addr == OFF_MIN && keyOk;
   wire wrHour = sfrBus.we && sfrBus.addr == OFF_HOUR && keyOk;
   wire wrCounter = wrFrac || wrSec || wrMin || wrHour;
   wire wrCfg = sfrBus.we && sfrBus.addr == OFF_CONFIG;
   wire wrTarget = sfrBus.we && sfrBus.addr == OFF_INTERVAL;

   // Signed trim sum, clamped so the tick period stays between 128 and 383 edges.
   wire signed [9:0] trimSum = $signed({{2{nominal_r[7]}}, nominal_r}) +
      $signed({{2{thermal_r[7]}}, thermal_r});
   wire signed [9:0] trimClamp = (trimSum > TRIM_MAX) ? TRIM_MAX :
      (trimSum < TRIM_MIN) ? TRIM_MIN : trimSum;
   // The adjustment is applied once per second, on the tick after the seconds carry.
   wire [9:0] tickLen = (frac_r == RST_BYTE) ?
      EDGES_PER_TICK + $unsigned(trimClamp) : EDGES_PER_TICK;
   wire xEdge = xSync2_r && !xPrev_r;
   wire fracTick = xEdge && (edgeCnt_r + 10'h_001 >= tickLen);

   // Cascade strobes.
   // The limit must keep all eight bits, or every hour would look like the last one.
   wire [7:0] hourLast = cfg_r.dayMode ? HOUR_LAST_24 : HOUR_LAST_256;
   wire secTick = fracTick && frac_r >= FRAC_LAST;
   wire minTick = secTick && sec_r >= SEC_LAST;
   wire hourTick = minTick && min_r >= MIN_LAST;
   wire dayTick = hourTick && hour_r >= hourLast;

   // Interval timebase selection and match.
   logic intTick;
   assign intTick = (cfg_r.timebase == TB_FRAC) ? fracTick :
      (cfg_r.timebase == TB_SEC) ? secTick :
      (cfg_r.timebase == TB_MIN) ? minTick : hourTick;
   wire intRun = cfg_r.intEn && !oneShotDone_r;
   wire [7:0] intNext = intCount_r + 8'h_01;
   wire intHit = intRun && intTick && intNext == intTarget_r;

   // Synchroniser and edge counter; these run from power-on only.
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         xSync1_r <= 1'b0;
         xSync2_r <= 1'b0;
         xPrev_r <= 1'b0;
         edgeCnt_r <= 10'h_000;
      end else begin
         xSync1_r <= xtalClk;
         xSync2_r <= xSync1_r;
         xPrev_r <= xSync2_r;
         if (xEdge) begin
            edgeCnt_r <= fracTick ? 10'h_000 : edgeCnt_r + 10'h_001;
         end
      end
   end

   // Timekeeping counters ignore sysRst so time survives a system reset.
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         frac_r <= RST_BYTE;
         sec_r <= RST_BYTE;
         min_r <= RST_BYTE;
         hour_r <= RST_BYTE;
      end else begin
         // A keyed write wins over a same-cycle increment of that counter.
         frac_r <= wrFrac ? sfrBus.data : fracTick ? wrapInc(frac_r, FRAC_LAST) : frac_r;
         sec_r <= wrSec ? sfrBus.data : secTick ? wrapInc(sec_r, SEC_LAST) : sec_r;
         min_r <= wrMin ? sfrBus.data : minTick ? wrapInc(min_r, MIN_LAST) : min_r;
         hour_r <= wrHour ? sfrBus.data : hourTick ? wrapInc(hour_r, hourLast) : hour_r;
      end
   end

   // Configuration in one process so the whole struct has a single driver.
   // Flags clear by writing zero, and a set wins over a clear in the same cycle.
   always_ff @(posedge clk_sys) begin
      if (rst || sysRst) begin
         cfg_r.dayFlag <= 1'b0;
         cfg_r.timebase <= TB_FRAC;
         cfg_r.oneShot <= 1'b0;
         cfg_r.alarm <= 1'b0;
         cfg_r.intEn <= 1'b0;
         cfg_r.alwaysOn <= 1'b1;
         // The hour mode bit survives sysRst so the wrap does not change under software.
         if (rst) begin
            cfg_r.dayMode <= 1'b0;
         end
      end else begin
         cfg_r.dayFlag <= dayTick || (cfg_r.dayFlag && !(wrCfg && !sfrBus.data[BIT_DAY_FLAG]));
         cfg_r.alarm <= intHit || (cfg_r.alarm && !(wrCfg && !sfrBus.data[BIT_ALARM]));
         if (wrCfg) begin
            cfg_r.dayMode <= sfrBus.data[BIT_DAY_MODE];
            cfg_r.timebase <= rtctk_tb_e'(sfrBus.data[BIT_TB_HI:BIT_TB_LO]);
            cfg_r.oneShot <= sfrBus.data[BIT_ONE_SHOT];
            cfg_r.intEn <= sfrBus.data[BIT_INT_EN];
         end
      end
   end

   // Interval counter; disabling it resets the count and rearms a one-shot.
   always_ff @(posedge clk_sys) begin
      if (rst || sysRst || !cfg_r.intEn) begin
         intCount_r <= RST_BYTE;
         oneShotDone_r <= 1'b0;
      end else if (wrTarget) begin
         intCount_r <= RST_BYTE;
         oneShotDone_r <= 1'b0;
      end else if (intRun && intTick) begin
         intCount_r <= intHit ? RST_BYTE : intNext;
         oneShotDone_r <= intHit && cfg_r.oneShot;
      end
   end

   // Software-loaded registers; all clear on any reset.
   always_ff @(posedge clk_sys) begin
      if (rst || sysRst) begin
         intTarget_r <= RST_BYTE;
         nominal_r <= RST_BYTE;
         thermal_r <= RST_BYTE;
         key_r <= RST_BYTE;
      end else begin
         if (wrTarget) intTarget_r <= sfrBus.data;
         if (sfrBus.we && sfrBus.addr == OFF_NOMINAL) nominal_r <= sfrBus.data;
         if (sfrBus.we && sfrBus.addr == OFF_THERMAL) thermal_r <= sfrBus.data;
         // Any counter write consumes the key, so each write needs a fresh one.
         if (wrCounter) key_r <= RST_BYTE;
         else if (sfrBus.we && sfrBus.addr == OFF_KEY) key_r <= sfrBus.data;
      end
   end

   // Read mux; unmapped offsets read zero.
   logic [7:0] rdMux;
   assign rdMux = (sfrBus.addr == OFF_CONFIG) ? cfg_r :
      (sfrBus.addr == OFF_FRAC) ? frac_r :
      (sfrBus.addr == OFF_SEC) ? sec_r :
      (sfrBus.addr == OFF_MIN) ? min_r :
      (sfrBus.addr == OFF_HOUR) ? hour_r :
      (sfrBus.addr == OFF_INTERVAL) ? intTarget_r :
      (sfrBus.addr == OFF_KEY) ? key_r :
      (sfrBus.addr == OFF_NOMINAL) ? nominal_r :
      (sfrBus.addr == OFF_THERMAL) ? thermal_r : RST_BYTE;

   // Output registers; the request follows the flags one cycle later.
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         rdData_r <= RST_BYTE;
         irq_r <= 1'b0;
      end else begin
         rdData_r <= rdMux;
         irq_r <= cfg_r.dayFlag || cfg_r.alarm;
      end
   end
   assign sfrRdData = rdData_r;
   assign clkIrq = irq_r;

   // Checks on the behaviour above.
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);

   sequence sqSecWrap;
      secTick && sec_r == SEC_LAST && !wrSec && !wrMin;
   endsequence

   AST_FRAC_WRAP: assert property (fracTick && frac_r == FRAC_LAST && !wrFrac |=> frac_r == 8'h_00)
      else $error("fraction did not wrap");
   AST_SEC_CARRY: assert property (sqSecWrap |=> sec_r == 8'h_00 && min_r != $past(min_r))
      else $error("seconds carry wrong");
   AST_MIN_CARRY: assert property (minTick && min_r == MIN_LAST && !wrMin && !wrHour
      |=> min_r == 8'h_00 && hour_r != $past(hour_r))
      else $error("minutes carry wrong");
   AST_HOUR_24: assert property (hourTick && cfg_r.dayMode && hour_r == 8'h_17 && !wrHour
      |=> hour_r == 8'h_00 && cfg_r.dayFlag ##1 clkIrq)
      else $error("24-hour wrap wrong");
   AST_HOUR_256: assert property (hourTick && !cfg_r.dayMode && !wrHour
      |=> (hour_r == 8'h_00) == ($past(hour_r) == 8'h_FF))
      else $error("256-hour wrap wrong");
   AST_RETAIN: assert property (sysRst && !fracTick && !wrCounter |=> $stable(sec_r) && $stable(hour_r))
      else $error("time lost on system reset");
   AST_ALARM: assert property (intHit && !wrTarget |=> cfg_r.alarm && intCount_r == 8'h_00)
      else $error("alarm not raised");
   AST_ONE_SHOT: assert property (intHit && cfg_r.oneShot && !wrTarget && !wrCfg && !sysRst
      |=> !intRun [*2])
      else $error("one-shot kept running");
   AST_TRIM_CLEAR: assert property (sysRst |=> nominal_r == 8'h_00 && key_r == 8'h_00)
      else $error("trim not cleared");
   AST_NO_KEY: assert property (sfrBus.we && sfrBus.addr == OFF_SEC && !keyOk && !secTick
      |=> $stable(sec_r))
      else $error("unkeyed write took effect");
   AST_KEY_USED: assert property (wrCounter && !sysRst |=> key_r == 8'h_00)
      else $error("key not consumed");
   AST_IRQ: assert property (cfg_r.dayFlag || cfg_r.alarm |=> clkIrq)
      else $error("interrupt not held");
endmodule
`default_nettype wire

// File: rtctk_pkg.sv
/*
 Shared constants and types for the timekeeping counter block: register
 offsets, field positions, reset values and wrap limits.
 Assumes the processor's special-function bus uses 8-bit offsets and data.
*/
package rtctk_pkg;
   // Register offsets in the special-function space.
   localparam logic [7:0] OFF_CONFIG = 8'h_A1;
   localparam logic [7:0] OFF_FRAC = 8'h_A2;
   localparam logic [7:0] OFF_SEC = 8'h_A3;
   localparam logic [7:0] OFF_MIN = 8'h_A4;
   localparam logic [7:0] OFF_HOUR = 8'h_A5;
   localparam logic [7:0] OFF_INTERVAL = 8'h_A6;
   localparam logic [7:0] OFF_KEY = 8'h_C1;
   localparam logic [7:0] OFF_NOMINAL = 8'h_F6;
   localparam logic [7:0] OFF_THERMAL = 8'h_F7;
   // Field positions inside the configuration register.
   localparam int BIT_DAY_FLAG = 7;
   localparam int BIT_DAY_MODE = 6;
   localparam int BIT_TB_HI = 5;
   localparam int BIT_TB_LO = 4;
   localparam int BIT_ONE_SHOT = 3;
   localparam int BIT_ALARM = 2;
   localparam int BIT_INT_EN = 1;
   localparam int BIT_ALWAYS_ON = 0;
   // Reset values and magic numbers.
   localparam logic [7:0] RST_BYTE = 8'h_00;
   localparam logic [7:0] KEY_UNLOCK = 8'h_EA;
   // Wrap limits of the cascaded counters.
   localparam logic [7:0] FRAC_LAST = 8'h_7F;
   localparam logic [7:0] SEC_LAST = 8'h_3B;
   localparam logic [7:0] MIN_LAST = 8'h_3B;
   localparam logic [7:0] HOUR_LAST_24 = 8'h_17;
   localparam logic [7:0] HOUR_LAST_256 = 8'h_FF;
   // Crystal edges per 1/128 second tick at 32.768 kHz.
   localparam logic [9:0] EDGES_PER_TICK = 10'h_100;
   // Clamp bounds of the signed trim sum.
   localparam logic signed [9:0] TRIM_MAX = 10'sh_07F;
   localparam logic signed [9:0] TRIM_MIN = -10'sh_080;

   // Interval timebase codes.
   typedef enum logic [1:0] {
      TB_FRAC = 2'b00,
      TB_SEC = 2'b01,
      TB_MIN = 2'b10,
      TB_HOUR = 2'b11
   } rtctk_tb_e;

   // Configuration register contents.
   typedef struct packed {
      logic dayFlag;
      logic dayMode;
      rtctk_tb_e timebase;
      logic oneShot;
      logic alarm;
      logic intEn;
      logic alwaysOn;
   } rtctk_cfg_s;

   // One special-function bus cycle from the processor.
   typedef struct packed {
      logic we;
      logic [7:0] addr;
      logic [7:0] data;
   } rtctk_sfr_s;
endpackage

// File: rtctk_counters_test.sv
/*
 Self-checking bench for the timekeeping counter block.
 Assumes the crystal input is stepped by hand here, so ticks happen only
 inside pulse(), and both resets are driven directly on clk_sys.
*/
`timescale 1ns/1ps
`default_nettype none
module rtctk_counters_test;
   import rtctk_pkg::*;
   // Stimulus is held still at time zero and changed on falling edges.
   logic clk_sys = 1'b0;
   logic rst = 1'b1;
   logic sysRst = 1'b0;
   logic xtalClk = 1'b0;
   rtctk_sfr_s sfrBus = '0;
   wire logic [7:0] sfrRdData;
   wire logic clkIrq;
   int fails = 0;
   int totalChecks = 0;
   logic [7:0] rdVal;
   logic os;
   // Registers checked for their cleared value, the last one unmapped.
   logic [7:0] regs [9] = '{OFF_FRAC, OFF_SEC, OFF_MIN, OFF_HOUR, OFF_INTERVAL,
      OFF_KEY, OFF_NOMINAL, OFF_THERMAL, 8'h_10};
   // Hour wrap cases: mode bit, start hour, next hour and day flag.
   logic hrMode [3] = '{1'b1, 1'b0, 1'b0};
   logic [7:0] hrIn [3] = '{8'h_17, 8'h_17, 8'h_FF};
   logic [7:0] hrOut [3] = '{8'h_00, 8'h_18, 8'h_00};
   logic hrFlag [3] = '{1'b1, 1'b0, 1'b1};

   // The system clock runs at 40 MHz.
   always begin
      #12.5 clk_sys = ~clk_sys;
   end

   rtctk_counters i_dut (
      .clk_sys(clk_sys),
      .rst(rst),
      .sysRst(sysRst),
      .xtalClk(xtalClk),
      .sfrBus(sfrBus),
      .sfrRdData(sfrRdData),
      .clkIrq(clkIrq)
   );

   // Prints the verdict and ends the run; the only place that finishes.
   task automatic stopTest();
      if (fails == 0 && totalChecks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   // Compares with case equality so an unknown never counts as a match.
   task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
      totalChecks++;
      if (got !== exp) begin
         $display("mismatch %s expected %h seen %h", nm, exp, got);
         fails++;
      end
   endtask

   // One write strobe; the idle cycle after it keeps strobes apart.
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk_sys);
      sfrBus = '{we: 1'b1, addr: a, data: d};
      @(negedge clk_sys);
      sfrBus.we = 1'b0;
   endtask

   // Read data is registered, so it is taken one cycle after the address.
   task automatic rd(input logic [7:0] a);
      @(negedge clk_sys);
      sfrBus.addr = a;
      @(negedge clk_sys);
      rdVal = sfrRdData;
   endtask

   task automatic cr(input string nm, input logic [7:0] a, input logic [7:0] exp);
      rd(a);
      chk(nm, exp, rdVal);
   endtask

   // Counter writes each need a fresh key.
   task automatic keyed(input logic [7:0] a, input logic [7:0] d);
      wr(OFF_KEY, KEY_UNLOCK);
      wr(a, d);
   endtask

   task automatic prep(input logic [7:0] f, input logic [7:0] s, input logic [7:0] m,
         input logic [7:0] h);
      keyed(OFF_FRAC, f);
      keyed(OFF_SEC, s);
      keyed(OFF_MIN, m);
      keyed(OFF_HOUR, h);
   endtask

   // Three cycles per level leave room for the two-flop synchroniser.
   task automatic pulse(input int n);
      repeat (n) begin
         xtalClk = 1'b1;
         repeat (3) @(negedge clk_sys);
         xtalClk = 1'b0;
         repeat (3) @(negedge clk_sys);
      end
   endtask

   // Steps the crystal until the fraction moves, bounded by 300 crystal pulses.
   task automatic tick();
      logic [7:0] f0;
      rd(OFF_FRAC);
      f0 = rdVal;
      for (int i = 0; i < 300 && rdVal === f0; i++) begin
         pulse(1);
         rd(OFF_FRAC);
      end
      chk("frac step", (f0 == FRAC_LAST) ? 8'h_00 : f0 + 8'h_01, rdVal);
   endtask

   function automatic logic [7:0] cv(input logic df, input logic md, input logic [1:0] tb,
         input logic o, input logic al, input logic en);
      return {df, md, tb, o, al, en, 1'b1};
   endfunction

   // Cuts a hang short well above the longest expected run.
   initial begin
      repeat (90000) @(posedge clk_sys);
      fails++;
      stopTest();
   end

   initial begin
      repeat (12) @(negedge clk_sys);
      rst = 1'b0;
      cr("config", OFF_CONFIG, cv(1'b0, 1'b0, TB_FRAC, 1'b0, 1'b0, 1'b0));
      foreach (regs[i]) cr("reset value", regs[i], RST_BYTE);
      wr(OFF_SEC, 8'h_21);
      cr("locked sec", OFF_SEC, RST_BYTE);
      wr(OFF_KEY, 8'h_55);
      wr(OFF_SEC, 8'h_21);
      cr("bad key sec", OFF_SEC, RST_BYTE);
      keyed(OFF_SEC, 8'h_21);
      cr("keyed sec", OFF_SEC, 8'h_21);
      cr("key cleared", OFF_KEY, RST_BYTE);
      wr(OFF_NOMINAL, 8'h_55);
      wr(OFF_THERMAL, 8'h_12);
      wr(OFF_INTERVAL, 8'h_FF);
      cr("nominal", OFF_NOMINAL, 8'h_55);
      cr("thermal", OFF_THERMAL, 8'h_12);
      cr("target", OFF_INTERVAL, 8'h_FF);
      wr(OFF_CONFIG, cv(1'b0, 1'b1, TB_FRAC, 1'b0, 1'b0, 1'b0));
      wr(OFF_KEY, KEY_UNLOCK);
      // A watchdog reset keeps the time but clears the trims and the key.
      sysRst = 1'b1;
      repeat (2) @(negedge clk_sys);
      sysRst = 1'b0;
      cr("kept sec", OFF_SEC, 8'h_21);
      cr("nominal cleared", OFF_NOMINAL, RST_BYTE);
      cr("kept mode", OFF_CONFIG, cv(1'b0, 1'b1, TB_FRAC, 1'b0, 1'b0, 1'b0));
      cr("key cleared", OFF_KEY, RST_BYTE);
      rst = 1'b1;
      repeat (3) @(negedge clk_sys);
      rst = 1'b0;
      cr("sec power-on", OFF_SEC, RST_BYTE);
      // Tick period is exactly 256 crystal edges with zero trim.
      tick();
      pulse(255);
      cr("frac hold", OFF_FRAC, 8'h_01);
      pulse(1);
      cr("frac period", OFF_FRAC, 8'h_02);
      // A tick that starts at zero stretches by the signed trim sum, here 16 - 8 edges.
      keyed(OFF_FRAC, 8'h_00);
      wr(OFF_NOMINAL, 8'h_10);
      wr(OFF_THERMAL, 8'h_F8);
      pulse(263);
      cr("trim hold", OFF_FRAC, 8'h_00);
      pulse(1);
      cr("trim period", OFF_FRAC, 8'h_01);
      wr(OFF_NOMINAL, 8'h_00);
      wr(OFF_THERMAL, 8'h_00);
      for (int i = 0; i < 3; i++) begin
         wr(OFF_CONFIG, cv(1'b0, hrMode[i], TB_FRAC, 1'b0, 1'b0, 1'b0));
         prep(FRAC_LAST, SEC_LAST, MIN_LAST, hrIn[i]);
         tick();
         cr("sec wrap", OFF_SEC, 8'h_00);
         cr("min wrap", OFF_MIN, 8'h_00);
         cr("hour wrap", OFF_HOUR, hrOut[i]);
         cr("day flag", OFF_CONFIG, cv(hrFlag[i], hrMode[i], TB_FRAC, 1'b0, 1'b0, 1'b0));
         chk("irq day", {7'h_00, hrFlag[i]}, {7'h_00, clkIrq});
         wr(OFF_CONFIG, cv(1'b0, hrMode[i], TB_FRAC, 1'b0, 1'b0, 1'b0));
         cr("day cleared", OFF_CONFIG, cv(1'b0, hrMode[i], TB_FRAC, 1'b0, 1'b0, 1'b0));
         chk("irq cleared", 8'h_00, {7'h_00, clkIrq});
      end
      // Rounds 0 and 1 repeat, round 2 is one-shot, round 3 must stay quiet.
      wr(OFF_INTERVAL, 8'h_03);
      wr(OFF_CONFIG, cv(1'b0, 1'b1, TB_FRAC, 1'b0, 1'b0, 1'b1));
      for (int r = 0; r < 4; r++) begin
         os = (r >= 2);
         if (r == 2) begin
            wr(OFF_CONFIG, cv(1'b0, 1'b1, TB_FRAC, 1'b1, 1'b0, 1'b1));
            wr(OFF_INTERVAL, 8'h_03);
         end
         tick();
         tick();
         cr("alarm early", OFF_CONFIG, cv(1'b0, 1'b1, TB_FRAC, os, 1'b0, 1'b1));
         tick();
         cr("alarm", OFF_CONFIG, cv(1'b0, 1'b1, TB_FRAC, os, r != 3, 1'b1));
         chk("irq alarm", {7'h_00, r != 3}, {7'h_00, clkIrq});
         wr(OFF_CONFIG, cv(1'b0, 1'b1, TB_FRAC, os, 1'b0, 1'b1));
      end
      // The seconds, minutes and hours timebases each fire only when their own counter steps.
      for (int t = 1; t < 4; t++) begin
         for (int lvl = t - 1; lvl <= t; lvl++) begin
            wr(OFF_CONFIG, cv(1'b0, 1'b1, t[1:0], 1'b0, 1'b0, 1'b0));
            prep((lvl >= 1) ? FRAC_LAST : 8'h_10, (lvl >= 2) ? SEC_LAST : 8'h_00,
               (lvl >= 3) ? MIN_LAST : 8'h_00, 8'h_00);
            wr(OFF_INTERVAL, 8'h_01);
            wr(OFF_CONFIG, cv(1'b0, 1'b1, t[1:0], 1'b0, 1'b0, 1'b1));
            tick();
            cr("timebase", OFF_CONFIG, cv(1'b0, 1'b1, t[1:0], 1'b0, lvl == t, 1'b1));
         end
      end
      stopTest();
   end
endmodule
`default_nettype wire
